//--- include/rrc_map.svh
`ifndef RRC_MAP_SVH
`define RRC_MAP_SVH

// ==========================================================
// Register indices, loaded into the configuration index
`define RRC_IDX_UART2_BASE 8'h25
`define RRC_IDX_DMA_ROUTE 8'h26
`define RRC_IDX_IRQ_ROUTE 8'h27
`define RRC_IDX_SER_IRQ_ROUTE 8'h28

// ==========================================================
// Reset values
`define RRC_RESET_VALUE 8'h00

// ==========================================================
// Field positions
`define RRC_LO_SEL_MSB 3
`define RRC_HI_SEL_LSB 4
`define RRC_BASE_RSVD_BIT 0

// ==========================================================
// Selector codes
`define RRC_DMA_NONE 4'hF
`define RRC_DMA_CH1 4'h1
`define RRC_DMA_CH3 4'h3
`define RRC_IRQ_NONE 4'h0

`endif

//--- include/rrc_pkg.sv
package rrc_pkg;
    // Four-bit routing selector
    typedef logic [3:0] rrc_sel_t;
    // Byte-wide register value
    typedef logic [7:0] rrc_byte_t;
    // Register access kind seen by the bus slave
    typedef enum logic [1:0] {
        RRC_ACC_IDLE,
        RRC_ACC_READ,
        RRC_ACC_WRITE
    } rrc_acc_t;
endpackage

//--- src/rrc_uart2_decode.sv
`timescale 1ns/10ps
`include "rrc_map.svh"

// Second serial port address decoder
module rrc_uart2_decode (
    input wire logic [7:0] base_value,
    input wire logic [15:0] io_addr,
    input wire logic io_cycle,
    output logic uart2_enabled,
    output logic uart2_select,
    output logic [2:0] uart2_reg_offset
);
    import rrc_pkg::*;

    // ==========================================================
    // Decode
    always_comb begin
        uart2_enabled = (base_value[7:6] != 2'h0);
        uart2_select = io_cycle && uart2_enabled && (io_addr[15:10] == 6'h00)
            && (io_addr[9:3] == base_value[7:1]);
        // Register offset inside the port
        uart2_reg_offset = io_addr[2:0];
    end
endmodule

//--- src/rrc_line_drive.sv
`timescale 1ns/10ps
`include "rrc_map.svh"

// Drives fifteen shared lines from up to four sources
module rrc_line_drive (
    input wire logic [15:0] sel_flat,
    input wire logic [3:0] src_active,
    input wire logic [3:0] src_level,
    output logic [15:1] line_out,
    output logic [15:1] line_oe_n
);
    import rrc_pkg::*;

    // ==========================================================
    // One driver slot per line
    genvar n;
    generate
        for (n = 1; n <= 15; n++) begin : g_line
            logic [3:0] hit;
            // Which sources choose this line
            always_comb begin
                for (int s = 0; s < 4; s++) begin
                    hit[s] = src_active[s] && (sel_flat[s*4 +: 4] == 4'(n));
                end
            end
            assign line_oe_n[n] = ~(|hit);
            assign line_out[n] = |(hit & src_level);
        end
    endgenerate
endmodule

//--- src/rrc_routing_config.sv
`timescale 1ns/10ps
`include "rrc_map.svh"

module rrc_routing_config (
    // Host bus clock
    input wire logic clock,
    // Power-on reset, synchronous
    input wire logic reset,
    // High while in configuration state
    input wire logic config_state,
    // Index currently loaded by the host
    input wire logic [7:0] config_index_register,
    // Register index of this access
    input wire logic [7:0] cfg_addr,
    // Write data
    input wire logic [7:0] cfg_wdata,
    // One-cycle write strobe
    input wire logic cfg_write,
    // One-cycle read strobe
    input wire logic cfg_read,
    // Read data, cycle after strobe
    output rrc_pkg::rrc_byte_t cfg_rdata,
    // Host I/O address
    input wire logic [15:0] io_addr,
    // Host I/O cycle qualifier
    input wire logic io_cycle,
    // Second serial port switched on
    output logic uart2_enabled,
    // Second serial port address hit
    output logic uart2_select,
    // Register inside the port
    output logic [2:0] uart2_reg_offset,
    // Parallel port DMA request
    input wire logic parallel_dma_req,
    // Floppy controller DMA request
    input wire logic floppy_dma_req,
    // DMA channel request levels
    output logic [3:1] dma_req_out,
    // DMA channel drive enables, low drives
    output logic [3:1] dma_req_oe_n,
    // Parallel port interrupt level
    input wire logic parallel_irq,
    // Floppy controller interrupt level
    input wire logic floppy_irq,
    // First serial port interrupt level
    input wire logic serial_one_irq,
    // Second serial port interrupt level
    input wire logic serial_two_irq,
    // First serial port interrupt gate
    input wire logic serial_one_modem_aux_output_two,
    // Second serial port interrupt gate
    input wire logic serial_two_modem_aux_output_two,
    // Interrupt line levels
    output logic [15:1] irq_out,
    // Interrupt line drive enables, low drives
    output logic [15:1] irq_oe_n
);
    import rrc_pkg::*;

    // ==========================================================
    // Register state
    // Second serial port base, bits nine to three
    rrc_byte_t uart2_base_address_reg;
    // Its next value
    rrc_byte_t uart2_base_address_next;
    // DMA selectors for floppy and parallel
    rrc_byte_t fdc_pp_dma_route_reg;
    // Its next value
    rrc_byte_t fdc_pp_dma_route_next;
    // Interrupt selectors for floppy and parallel
    rrc_byte_t fdc_pp_irq_route_reg;
    // Its next value
    rrc_byte_t fdc_pp_irq_route_next;
    // Interrupt selectors for both serial ports
    rrc_byte_t serial_ports_irq_route_reg;
    // Its next value
    rrc_byte_t serial_ports_irq_route_next;
    // Registered read data
    rrc_byte_t cfg_rdata_reg;
    // Read data for the next cycle
    rrc_byte_t cfg_rdata_next;
    // Kind of strobe this cycle
    rrc_acc_t access_kind;
    // Access allowed by state and index
    logic access_ok;

    // ==========================================================
    // Access qualification
    always_comb begin
        // Classify the current strobe
        // Write wins if both strobes ever met
        if (cfg_write) begin
            access_kind = RRC_ACC_WRITE;
        end else if (cfg_read) begin
            // Read strobe alone
            access_kind = RRC_ACC_READ;
        end else begin
            // No strobe
            access_kind = RRC_ACC_IDLE;
        end
        // config state and index match
        // Outside config state nothing is touched
        access_ok = config_state && (cfg_addr == config_index_register);
    end

    // ==========================================================
    // Register next values
    always_comb begin
        uart2_base_address_next = uart2_base_address_reg;
        fdc_pp_dma_route_next = fdc_pp_dma_route_reg;
        fdc_pp_irq_route_next = fdc_pp_irq_route_reg;
        serial_ports_irq_route_next = serial_ports_irq_route_reg;
        if (access_kind == RRC_ACC_WRITE && access_ok) begin
            // Address decode of writes
            if (cfg_addr == `RRC_IDX_UART2_BASE) begin
                uart2_base_address_next = {cfg_wdata[7:1], 1'b0};
            end else if (cfg_addr == `RRC_IDX_DMA_ROUTE) begin
                // DMA selector byte
                fdc_pp_dma_route_next = cfg_wdata;
            end else if (cfg_addr == `RRC_IDX_IRQ_ROUTE) begin
                // Interrupt selector byte
                fdc_pp_irq_route_next = cfg_wdata;
            end else if (cfg_addr == `RRC_IDX_SER_IRQ_ROUTE) begin
                // Serial interrupt selector byte
                serial_ports_irq_route_next = cfg_wdata;
            end
            // Other indices belong elsewhere, ignored
        end
    end

    // ==========================================================
    // Read data next value
    always_comb begin
        // Unmapped or refused reads give zero
        cfg_rdata_next = 8'h00;
        if (access_kind == RRC_ACC_READ && access_ok) begin
            if (cfg_addr == `RRC_IDX_UART2_BASE) begin
                // Base, bit zero already stored as zero
                cfg_rdata_next = uart2_base_address_reg;
            end else if (cfg_addr == `RRC_IDX_DMA_ROUTE) begin
                // DMA selectors
                cfg_rdata_next = fdc_pp_dma_route_reg;
            end else if (cfg_addr == `RRC_IDX_IRQ_ROUTE) begin
                // Interrupt selectors
                cfg_rdata_next = fdc_pp_irq_route_reg;
            end else if (cfg_addr == `RRC_IDX_SER_IRQ_ROUTE) begin
                // Serial interrupt selectors
                cfg_rdata_next = serial_ports_irq_route_reg;
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clock) begin
        if (reset) begin
            uart2_base_address_reg <= `RRC_RESET_VALUE;
            fdc_pp_dma_route_reg <= `RRC_RESET_VALUE;
            fdc_pp_irq_route_reg <= `RRC_RESET_VALUE;
            serial_ports_irq_route_reg <= `RRC_RESET_VALUE;
            cfg_rdata_reg <= 8'h00;
        end else begin
            // Load the computed next values
            uart2_base_address_reg <= uart2_base_address_next;
            fdc_pp_dma_route_reg <= fdc_pp_dma_route_next;
            fdc_pp_irq_route_reg <= fdc_pp_irq_route_next;
            serial_ports_irq_route_reg <= serial_ports_irq_route_next;
            cfg_rdata_reg <= cfg_rdata_next;
        end
    end

    // Read data one cycle after strobe
    // Zero outside that cycle, so a stale value never lingers
    assign cfg_rdata = cfg_rdata_reg;

    // ==========================================================
    // Second serial port decode
    // Pure combinational decode of the stored base
    rrc_uart2_decode u_decode (
        // Stored base address
        .base_value(uart2_base_address_reg),
        // Host address
        .io_addr(io_addr),
        // Host cycle qualifier
        .io_cycle(io_cycle),
        // Port switched on
        .uart2_enabled(uart2_enabled),
        // Address hit
        .uart2_select(uart2_select),
        // Register offset
        .uart2_reg_offset(uart2_reg_offset)
    );

    // ==========================================================
    // DMA routing
    // Two functions share three channels
    // A clash is a software error; parallel is given priority
    // Channel pins float unless a valid code picks them
    // Parallel port DMA code
    rrc_sel_t parallel_dma_selector;
    // Floppy controller DMA code
    rrc_sel_t floppy_dma_selector;
    // Code names a real channel, per function
    logic [1:0] dma_src_valid;

    always_comb begin
        parallel_dma_selector = fdc_pp_dma_route_reg[`RRC_LO_SEL_MSB:0];
        floppy_dma_selector = fdc_pp_dma_route_reg[7:`RRC_HI_SEL_LSB];
        // only codes one to three route
        dma_src_valid[0] = (parallel_dma_selector >= `RRC_DMA_CH1)
            && (parallel_dma_selector <= `RRC_DMA_CH3);
        dma_src_valid[1] = (floppy_dma_selector >= `RRC_DMA_CH1)
            && (floppy_dma_selector <= `RRC_DMA_CH3);
        for (int c = 1; c <= 3; c++) begin
            // Default: channel floats, level low
            dma_req_oe_n[c] = 1'b1;
            dma_req_out[c] = 1'b0;
            if (dma_src_valid[0] && parallel_dma_selector == 4'(c)) begin
                // Parallel port owns this channel
                dma_req_oe_n[c] = 1'b0;
                dma_req_out[c] = parallel_dma_req;
            end else if (dma_src_valid[1] && floppy_dma_selector == 4'(c)) begin
                // Floppy controller owns this channel
                dma_req_oe_n[c] = 1'b0;
                dma_req_out[c] = floppy_dma_req;
            end
        end
    end

    // ==========================================================
    // Interrupt routing
    // Four sources, fifteen lines, code zero routes nowhere
    // Shared lines are a software error; levels are ORed
    // so that the model stays defined, not to support sharing
    // Parallel port line code
    rrc_sel_t parallel_irq_selector;
    // Floppy controller line code
    rrc_sel_t floppy_irq_selector;
    // First serial port line code
    rrc_sel_t serial_one_irq_selector;
    // Second serial port line code
    rrc_sel_t serial_two_irq_selector;
    // Source may drive its line
    logic [3:0] irq_active;
    // Source interrupt level
    logic [3:0] irq_level;

    always_comb begin
        parallel_irq_selector = fdc_pp_irq_route_reg[`RRC_LO_SEL_MSB:0];
        floppy_irq_selector = fdc_pp_irq_route_reg[7:`RRC_HI_SEL_LSB];
        serial_one_irq_selector = serial_ports_irq_route_reg[7:`RRC_HI_SEL_LSB];
        serial_two_irq_selector = serial_ports_irq_route_reg[`RRC_LO_SEL_MSB:0];
        irq_active = {serial_two_modem_aux_output_two, serial_one_modem_aux_output_two,
            2'b11};
        irq_level = {serial_two_irq, serial_one_irq, floppy_irq, parallel_irq};
    end

    rrc_line_drive u_irq (
        // Selector per source, source zero lowest
        .sel_flat({serial_two_irq_selector, serial_one_irq_selector,
            floppy_irq_selector, parallel_irq_selector}),
        // Serial sources gated by their aux output
        .src_active(irq_active),
        // Source levels
        .src_level(irq_level),
        // Line levels
        .line_out(irq_out),
        // Line drive enables
        .line_oe_n(irq_oe_n)
    );
endmodule

//--- verif/rrc_host_model.sv
`timescale 1ns/10ps
// ====================
// Host doing config cycles
module rrc_host_model (
    input wire logic clock,
    output logic config_state,
    output logic [7:0] config_index_register,
    output logic [7:0] cfg_addr,
    output logic [7:0] cfg_wdata,
    output logic cfg_write,
    output logic cfg_read
);
    // Idle bus at time zero
    initial begin
        config_state = 1'b0;
        config_index_register = 8'h00;
        cfg_addr = 8'h00;
        cfg_wdata = 8'h00;
        cfg_write = 1'b0;
        cfg_read = 1'b0;
    end
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w, input logic ok);
        @(posedge clock);
        config_state <= ok;
        config_index_register <= a;
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_write <= w;
        cfg_read <= !w;
    endtask
    // Release strobes, data shows inverse
    task automatic idle;
        @(posedge clock);
        cfg_write <= 1'b0;
        cfg_read <= 1'b0;
        cfg_wdata <= ~cfg_wdata;
    endtask
endmodule

//--- verif/rrc_routing_config_properties.sv
`timescale 1ns/10ps
// ====================
// Routing config checker
module rrc_routing_config_properties (
    input wire logic clock,
    input wire logic reset,
    input wire logic config_state,
    input wire logic [7:0] config_index_register,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_write,
    input wire logic cfg_read,
    input wire rrc_pkg::rrc_byte_t cfg_rdata,
    input wire logic [15:0] io_addr,
    input wire logic uart2_enabled,
    input wire logic uart2_select,
    input wire logic [3:1] dma_req_oe_n,
    input wire logic [15:1] irq_oe_n
);
    import rrc_pkg::*;
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    // Access would be taken
    wire acc_hit = config_state && cfg_addr == config_index_register;
    sequence wr_dma;
        cfg_write && acc_hit && cfg_addr == 8'h26;
    endsequence
    sequence rd_dma;
        cfg_read && acc_hit && cfg_addr == 8'h26;
    endsequence
    rd_refused_a: assert property (cfg_read && !acc_hit |=> cfg_rdata == 8'h00)
        else $error("refused read gave data");
    rd_idle_a: assert property (!cfg_read |=> cfg_rdata == 8'h00)
        else $error("read data outside its cycle");
    base_bit_zero_a: assert property (cfg_read && cfg_addr == 8'h25 |=> !cfg_rdata[0])
        else $error("base bit zero read one");
    dma_readback_a: assert property (wr_dma ##1 rd_dma |=> cfg_rdata == $past(cfg_wdata, 2))
        else $error("dma route read back wrong");
    port_off_a: assert property (!uart2_enabled |-> !uart2_select)
        else $error("disabled port selected");
    upper_zero_a: assert property (uart2_select |-> io_addr[15:10] == 6'h00)
        else $error("select with upper bits set");
    reset_float_a: assert property ($past(reset) |-> &dma_req_oe_n && &irq_oe_n)
        else $error("line driven after reset");
    dma_none_a: assert property (wr_dma ##0 (cfg_wdata[3:2] != 2'b00 && cfg_wdata[7:6] != 2'b00)
        |=> &dma_req_oe_n)
        else $error("reserved dma code drives");
endmodule
bind rrc_routing_config rrc_routing_config_properties rrc_routing_config_properties_inst (
    .clock, .reset, .config_state, .config_index_register, .cfg_addr, .cfg_wdata, .cfg_write,
    .cfg_read, .cfg_rdata, .io_addr, .uart2_enabled, .uart2_select, .dma_req_oe_n, .irq_oe_n);

//--- verif/test_rrc_routing_config.sv
`timescale 1ns/10ps
// ====================
// Self-checking bench
module test_rrc_routing_config;
    import rrc_pkg::*;
    logic clock = 0;
    logic reset = 1;
    wire config_state, cfg_write, cfg_read;
    wire [7:0] config_index_register, cfg_addr, cfg_wdata;
    rrc_byte_t cfg_rdata, d;
    logic [15:0] io_addr = 0;
    logic io_cycle = 0, pdma = 0, fdma = 0, pirq = 0, firq = 0;
    logic s1irq = 0, s2irq = 0, aux1 = 0, aux2 = 0, rd_seen = 0;
    logic uart2_enabled, uart2_select;
    logic [2:0] uart2_reg_offset;
    logic [3:1] dout, doe_n;
    logic [15:1] iout, ioe_n;
    logic [15:0] e;
    int fails = 0, compares = 0, c;
    rrc_byte_t exp_q[$];
    always #50 clock = ~clock;
    rrc_host_model rrc_host_model_inst (.clock, .config_state, .config_index_register,
        .cfg_addr, .cfg_wdata, .cfg_write, .cfg_read);
    rrc_routing_config rrc_routing_config_inst (.clock, .reset, .config_state,
        .config_index_register, .cfg_addr, .cfg_wdata, .cfg_write, .cfg_read, .cfg_rdata,
        .io_addr, .io_cycle, .uart2_enabled, .uart2_select, .uart2_reg_offset,
        .parallel_dma_req(pdma), .floppy_dma_req(fdma), .dma_req_out(dout),
        .dma_req_oe_n(doe_n), .parallel_irq(pirq), .floppy_irq(firq),
        .serial_one_irq(s1irq), .serial_two_irq(s2irq), .serial_one_modem_aux_output_two(aux1),
        .serial_two_modem_aux_output_two(aux2), .irq_out(iout), .irq_oe_n(ioe_n));
    // Compare and count
    task automatic cmp(input string n, input logic [15:0] x, input logic [15:0] s);
        compares++;
        if (s !== x) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic close_out;
        if (fails == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        rrc_host_model_inst.acc(a, v, 1'b1, 1'b1);
    endtask
    // Note expectation, then read
    task automatic rd(input logic [7:0] a, input logic ok, input logic [7:0] x);
        exp_q.push_back(x);
        rrc_host_model_inst.acc(a, 8'h00, 1'b0, ok);
    endtask
    // Read data checker, one cycle after strobe
    always @(posedge clock) begin
        rd_seen <= cfg_read;
        if (rd_seen) cmp("cfg_rdata", exp_q.pop_front(), cfg_rdata);
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        close_out;
    end
    initial begin
        void'($urandom(93515));
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        for (c = 0; c < 4; c++) rd(8'h25 + c[7:0], 1'b1, 8'h00);
        rrc_host_model_inst.acc(8'h26, 8'h21, 1'b1, 1'b0);
        rd(8'h26, 1'b0, 8'h00);
        rd(8'h26, 1'b1, 8'h00);
        rd(8'h29, 1'b1, 8'h00);
        rrc_host_model_inst.idle();
        #1 cmp("dma_req_oe_n", 16'h7, doe_n);
        cmp("irq_oe_n", 16'hFFFF, {ioe_n, 1'b1});
        d = 8'($urandom) | 8'h41;
        wr(8'h25, d);
        rd(8'h25, 1'b1, d & 8'hFE);
        rrc_host_model_inst.idle();
        io_addr <= {6'h00, d[7:1], 3'($urandom)};
        io_cycle <= 1'b1;
        #1 cmp("uart2_select", 16'h1, uart2_select);
        cmp("uart2_reg_offset", io_addr[2:0], uart2_reg_offset);
        @(posedge clock);
        io_addr <= io_addr | 16'h0400;
        #1 cmp("uart2_select", 16'h0, uart2_select);
        @(posedge clock);
        io_addr <= io_addr & 16'h03FF;
        io_cycle <= 1'b0;
        #1 cmp("uart2_select", 16'h0, uart2_select);
        wr(8'h25, 8'h3E);
        rrc_host_model_inst.idle();
        io_addr <= 16'h00F8;
        io_cycle <= 1'b1;
        #1 cmp("uart2_enabled", 16'h0, uart2_enabled);
        cmp("uart2_select", 16'h0, uart2_select);
        for (c = 0; c < 16; c++) begin
            wr(8'h26, {4'hF, c[3:0]});
            rd(8'h26, 1'b1, {4'hF, c[3:0]});
            rrc_host_model_inst.idle();
            pdma <= 1'($urandom);
            e = (c > 0 && c < 4) ? ~(16'h1 << (c - 1)) : 16'hFFFF;
            #1 cmp("dma_req_oe_n", {13'h0, e[2:0]}, doe_n);
            if (c > 0 && c < 4) cmp("dma_req_out", pdma, dout[c]);
        end
        wr(8'h26, 8'h2F);
        rrc_host_model_inst.idle();
        fdma <= 1'($urandom);
        #1 cmp("dma_req_oe_n", 16'h5, doe_n);
        cmp("dma_req_out", fdma, dout[2]);
        for (c = 0; c < 17; c++) begin
            wr(8'h27, (c < 16) ? {4'h0, c[3:0]} : 8'h50);
            rrc_host_model_inst.idle();
            pirq <= 1'($urandom);
            firq <= 1'($urandom);
            e = ~(16'h1 << ((c < 16) ? c : 5)) | 16'h1;
            #1 cmp("irq_oe_n", e, {ioe_n, 1'b1});
            if (c > 0 && c < 16) cmp("irq_out", pirq, iout[c]);
            if (c == 16) cmp("irq_out", firq, iout[5]);
        end
        wr(8'h27, 8'h00);
        wr(8'h28, 8'h34);
        rd(8'h28, 1'b1, 8'h34);
        rrc_host_model_inst.idle();
        for (c = 0; c < 16; c++) begin
            @(posedge clock);
            {aux1, aux2, s1irq, s2irq} <= c[3:0];
            e = 16'hFFFF & ~{11'h0, c[2], c[3], 3'h0};
            #1 cmp("irq_oe_n", e, {ioe_n, 1'b1});
            if (c[3]) cmp("irq_out", c[1], iout[3]);
            if (c[2]) cmp("irq_out", c[0], iout[4]);
        end
        repeat (3) @(posedge clock);
        close_out;
    end
endmodule
